/* File: asd_pkg.sv */
// Purpose: Shared constants and types of the asynchronous serial datapath
// Assumes: 50 MHz system clock, receiver oversampling at sixteen times the baud rate
// Notes: Sample phases are held as RT number minus one
package asd_pkg;
    // System clock rate in Hz
    localparam int CLK_HZ = 50_000_000;
    // Default baud rate in bit/s
    localparam int BAUD_RATE = 9600;
    // Sample ticks per bit time
    localparam int RT_PER_BIT = 16;
    // Clock cycles per sample tick
    localparam int RT_DIV_DEF = CLK_HZ / (RT_PER_BIT * BAUD_RATE);
    // Depth and width of the transmit FIFO
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 9;
    // Frame lengths in bit times, start and stop included
    localparam logic [3:0] LEN_EIGHT = 4'hA;
    localparam logic [3:0] LEN_NINE = 4'hB;
    // Data bit counts
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    // Sample phase positions
    localparam logic [3:0] PH_RT3 = 4'h2;
    localparam logic [3:0] PH_RT5 = 4'h4;
    localparam logic [3:0] PH_RT7 = 4'h6;
    localparam logic [3:0] PH_RT8 = 4'h7;
    localparam logic [3:0] PH_RT9 = 4'h8;
    localparam logic [3:0] PH_RT10 = 4'h9;
    localparam logic [3:0] PH_RT16 = 4'hF;
    // Window around a bit boundary where a falling edge resynchronises
    localparam logic [3:0] PH_EDGE_LATE = 4'h3;
    // Number of ones that must precede a start edge
    localparam logic [1:0] ONES_NEEDED = 2'h3;
    // Reset values of flags
    localparam logic TX_EMPTY_RST = 1'b1;
    // Transmit states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PRE = 2'b01,
        TX_DATA = 2'b10,
        TX_BRK = 2'b11
    } asd_tx_st_t;
    // Receive states
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10
    } asd_rx_st_t;
endpackage

/* File: asd_remote.sv */
// Purpose: Remote serial device model, sends frames and decodes received ones
// Assumes: Bit time in ns matches the device baud setting, idle line high
// Notes: A released transmit pin reads as pulled up
module asd_remote #(
    parameter int BIT_NS = 640
) (
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutOe,
    input wire logic inv,
    input wire logic nine
);
    timeunit 1ns;
    timeprecision 1ns;
    // Line as seen by the remote, pull-up when released, polarity undone
    wire line = (serialOutOe ? serialOut : 1'b1) ^ inv;
    // Last decoded character, stop bit on top
    logic [9:0] got;
    // Raised once per decoded character
    event gotEv;
    // Frame sender: start, data, stop, then three idle bits
    task automatic send(input logic [8:0] d, input logic stopBit);
        serialIn = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            serialIn = d[i];
            #(BIT_NS);
        end
        serialIn = stopBit;
        #(BIT_NS);
        serialIn = 1'b1;
        #(3 * BIT_NS);
    endtask
    // Idle level at time zero
    initial serialIn = 1'b1;
    // Frame receiver, pulses shorter than half a bit are ignored
    initial begin
        forever begin
            @(negedge line);
            #(BIT_NS / 2);
            if (line == 1'b0) begin
                got = '0;
                for (int i = 0; i < (nine ? 9 : 8); i++) begin
                    #(BIT_NS);
                    got[i] = line;
                end
                #(BIT_NS);
                got[9] = line;
                ->gotEv;
            end
        end
    end
endmodule

/* File: asd_serial.sv */
// Purpose: Full duplex asynchronous serial port with transmit FIFO
// Assumes: Control bits arrive as plain ports on clk; serialIn is asynchronous
// Notes: Phase counter value n stands for sample RT(n+1)
// Notes on behaviour
// - Transmit eight or nine bit characters
// - Preamble of ones on each transmit enable
// - Frame data with zero start, one stop
// - Empty flag sets on buffer handoff
// - Idle line is one; disable releases pin
// - Break characters repeat, then one one
// - All zero frame with zero stop is break
// - Break sets flags, clears data and ninth
// - Enable toggle queues idle character
// - Invert every transmitted level when asked
// - Done flag when nothing left to send
// - Receive eight or nine bit characters
// - Full character moves to buffer, flag sets
// - Sample input at sixteen times baud
// - Resynchronise after start and falling edges
// - Start search: zero after three ones
// - Verify start with samples three, five, seven
// - Data bit by majority, noise on disagreement
// - Late start samples only raise noise
// - Stop bit majority zero means framing error
// - Framing error sets with full flag

// Synchronous FIFO, storage in flip-flops
module asd_fifo #(
    parameter int WIDTH = asd_pkg::FIFO_WIDTH,
    parameter int DEPTH = asd_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    // Whole FIFO state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } asd_fifo_st_t;
    asd_fifo_st_t s_q, s_d;
    logic push, pop;
    // Full only when the count has reached the depth
    assign inReady = (s_q.cnt != (AW+1)'(DEPTH));
    assign outValid = (s_q.cnt != '0);
    assign outData = s_q.mem[s_q.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    // Pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// Serial port top
module asd_serial #(
    parameter int RT_DIV = asd_pkg::RT_DIV_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic portEnable,
    input wire logic txEnable,
    input wire logic sendBreak,
    input wire logic txInvert,
    input wire logic charNineBitSel,
    input wire logic txEmptyIrqEn,
    input wire logic txDoneIrqEn,
    input wire logic rxFullIrqEn,
    input wire logic statusRead,
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    input wire logic txNinthBit,
    input wire logic rxRead,
    output logic [7:0] rxData,
    output logic rxNinthBit,
    output logic txEmptyFlag,
    output logic txDoneFlag,
    output logic rxFullFlag,
    output logic framingErrFlag,
    output logic noiseFlag,
    output logic breakFlag,
    output logic overrunFlag,
    output logic rxActiveFlag,
    output logic txIrq,
    output logic rxIrq,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutOe
);
    // Whole port state
    typedef struct packed {
        logic [1:0] rxSync;
        logic [15:0] rtCnt;
        logic rtTick;
        asd_pkg::asd_tx_st_t txSt;
        logic [10:0] txSh;
        logic [3:0] txBits;
        logic [3:0] txPh;
        logic txEnPrev;
        logic idleQ;
        logic brkTail;
        logic txEmpty;
        logic armed;
        logic outLvl;
        logic outOe;
        asd_pkg::asd_rx_st_t rxSt;
        logic [3:0] rxPh;
        logic [1:0] ones;
        logic [3:0] rxIdx;
        logic [8:0] rxSh;
        logic [1:0] smp;
        logic lastSmp;
        logic edgeArm;
        logic noiseAcc;
        logic [7:0] data;
        logic ninth;
        logic full;
        logic fe;
        logic nf;
        logic bk;
        logic ovr;
    } asd_st_t;
    asd_st_t s_q, s_d;
    logic [1:0] rstSync_q;
    logic rstN;
    logic fifoValid, fifoPop, txPush;
    logic [8:0] fifoData;
    logic smpBit, frameEnd, loadNow, rxDone, bitMaj, bitDis;
    logic [2:0] v;
    logic [3:0] frameLen, dataBits;

    // Majority of three samples
    function automatic logic maj3(input logic [2:0] x);
        maj3 = (x[0] & x[1]) | (x[0] & x[2]) | (x[1] & x[2]);
    endfunction
    // Three samples disagree
    function automatic logic dis3(input logic [2:0] x);
        dis3 = (|x) & ~(&x);
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // Transmit data buffer
    asd_fifo #(.WIDTH(asd_pkg::FIFO_WIDTH), .DEPTH(asd_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstN(rstN),
        .inValid(txValid),
        .inReady(txReady),
        .inData({txNinthBit, txData}),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    assign txPush = txValid && txReady;
    assign smpBit = s_q.rxSync[1];
    assign frameLen = charNineBitSel ? asd_pkg::LEN_NINE : asd_pkg::LEN_EIGHT;
    assign dataBits = charNineBitSel ? asd_pkg::BITS_NINE : asd_pkg::BITS_EIGHT;
    assign frameEnd = s_q.rtTick && s_q.txPh == asd_pkg::PH_RT16 && s_q.txBits == 4'h1;
    assign loadNow = (s_q.txSt == asd_pkg::TX_IDLE) || frameEnd;
    // Current sample set: RT10 or RT7 now, earlier two held
    assign v = {smpBit, s_q.smp};
    assign bitMaj = maj3(v);
    assign bitDis = dis3(v);

    // Next state of transmitter and receiver
    always_comb begin
        s_d = s_q;
        fifoPop = 1'b0;
        rxDone = 1'b0;
        s_d.rxSync = {s_q.rxSync[0], serialIn};
        s_d.rtTick = (s_q.rtCnt == 16'(RT_DIV - 1));
        s_d.rtCnt = s_d.rtTick ? 16'h0 : s_q.rtCnt + 16'h1;
        // Empty flag clears on write after status read
        if (statusRead) begin
            s_d.armed = 1'b1;
        end
        if (txPush && s_q.armed) begin
            s_d.txEmpty = 1'b0;
            s_d.armed = 1'b0;
        end
        s_d.txEnPrev = txEnable;
        if (txEnable && !s_q.txEnPrev) begin
            s_d.idleQ = 1'b1;
        end
        // Shift one bit per sixteen ticks
        if (s_q.txSt != asd_pkg::TX_IDLE && s_q.rtTick) begin
            s_d.txPh = s_q.txPh + 4'h1;
            if (s_q.txPh == asd_pkg::PH_RT16) begin
                s_d.txSh = {1'b1, s_q.txSh[10:1]};
                s_d.txBits = s_q.txBits - 4'h1;
            end
        end
        if (loadNow) begin
            s_d.txPh = 4'h0;
            s_d.txBits = frameLen;
            if (!portEnable) begin
                s_d.txSt = asd_pkg::TX_IDLE;
            end else if (sendBreak) begin
                s_d.txSt = asd_pkg::TX_BRK;
                s_d.txSh = 11'h0;
                s_d.brkTail = 1'b1;
            end else if (s_q.brkTail) begin
                s_d.txSt = asd_pkg::TX_PRE;
                s_d.txSh = 11'h7FF;
                s_d.txBits = 4'h1;
                s_d.brkTail = 1'b0;
            end else if (s_d.idleQ && txEnable) begin
                s_d.txSt = asd_pkg::TX_PRE;
                s_d.txSh = 11'h7FF;
                s_d.idleQ = 1'b0;
            end else if (txEnable && fifoValid) begin
                s_d.txSt = asd_pkg::TX_DATA;
                s_d.txSh = {1'b1, charNineBitSel ? fifoData[8] : 1'b1, fifoData[7:0], 1'b0};
                fifoPop = 1'b1;
                s_d.txEmpty = 1'b1;
            end else begin
                s_d.txSt = asd_pkg::TX_IDLE;
            end
        end
        if (!portEnable) begin
            s_d.txSt = asd_pkg::TX_IDLE;
        end
        s_d.outLvl = ((s_d.txSt == asd_pkg::TX_IDLE) ? 1'b1 : s_d.txSh[0]) ^ txInvert;
        s_d.outOe = portEnable;
        // Flags clear on data read
        if (rxRead) begin
            s_d.full = 1'b0;
            s_d.fe = 1'b0;
            s_d.nf = 1'b0;
            s_d.bk = 1'b0;
            s_d.ovr = 1'b0;
        end
        if (s_q.rtTick) begin
            s_d.lastSmp = smpBit;
            s_d.rxPh = s_q.rxPh + 4'h1;
            case (s_q.rxSt)
                asd_pkg::RX_HUNT: begin
                    s_d.ones = (s_q.ones == asd_pkg::ONES_NEEDED) ? s_q.ones : s_q.ones + 2'h1;
                    if (!smpBit) begin
                        s_d.ones = 2'h0;
                    end
                    if (!smpBit && s_q.ones == asd_pkg::ONES_NEEDED) begin
                        s_d.rxSt = asd_pkg::RX_START;
                        s_d.rxPh = 4'h1;
                        s_d.noiseAcc = 1'b0;
                        s_d.rxSh = 9'h0;
                        s_d.rxIdx = 4'h0;
                    end
                end
                asd_pkg::RX_START: begin
                    if (s_q.rxPh == asd_pkg::PH_RT3) begin
                        s_d.smp[0] = smpBit;
                    end
                    if (s_q.rxPh == asd_pkg::PH_RT5) begin
                        s_d.smp[1] = smpBit;
                    end
                    if (s_q.rxPh == asd_pkg::PH_RT7) begin
                        if (bitMaj) begin
                            s_d.rxSt = asd_pkg::RX_HUNT;
                            s_d.ones = 2'h0;
                        end else if (bitDis) begin
                            s_d.noiseAcc = 1'b1;
                        end
                    end
                    if (s_q.rxPh >= asd_pkg::PH_RT8 && s_q.rxPh <= asd_pkg::PH_RT10 && smpBit) begin
                        s_d.noiseAcc = 1'b1;
                    end
                    if (s_q.rxPh == asd_pkg::PH_RT16) begin
                        s_d.rxSt = asd_pkg::RX_DATA;
                        s_d.edgeArm = 1'b0;
                    end
                end
                asd_pkg::RX_DATA: begin
                    if (s_q.rxPh == asd_pkg::PH_RT8) begin
                        s_d.smp[0] = smpBit;
                    end
                    if (s_q.rxPh == asd_pkg::PH_RT9) begin
                        s_d.smp[1] = smpBit;
                    end
                    if (s_q.edgeArm && s_q.lastSmp && !smpBit
                        && (s_q.rxPh > asd_pkg::PH_RT10 || s_q.rxPh <= asd_pkg::PH_EDGE_LATE)) begin
                        s_d.rxPh = 4'h1;
                        s_d.edgeArm = 1'b0;
                    end
                    if (s_q.rxPh == asd_pkg::PH_RT10) begin
                        if (bitDis) begin
                            s_d.noiseAcc = 1'b1;
                        end
                        s_d.edgeArm = bitMaj;
                        if (s_q.rxIdx != dataBits) begin
                            s_d.rxSh[s_q.rxIdx] = bitMaj;
                            s_d.rxIdx = s_q.rxIdx + 4'h1;
                        end else begin
                            rxDone = 1'b1;
                            s_d.rxSt = asd_pkg::RX_HUNT;
                            s_d.ones = bitMaj ? asd_pkg::ONES_NEEDED : 2'h0;
                            s_d.full = 1'b1;
                            s_d.nf = s_q.nf | s_d.noiseAcc;
                            s_d.fe = s_q.fe | !bitMaj;
                            if (s_q.full) begin
                                s_d.ovr = 1'b1;
                            end else begin
                                s_d.data = s_q.rxSh[7:0];
                                s_d.ninth = charNineBitSel ? s_q.rxSh[8] : s_q.rxSh[7];
                            end
                            if (!bitMaj && (charNineBitSel ? s_q.rxSh == 9'h0 : s_q.rxSh[7:0] == 8'h0)) begin
                                s_d.bk = 1'b1;
                                s_d.data = 8'h0;
                                s_d.ninth = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    s_d.rxSt = asd_pkg::RX_HUNT;
                end
            endcase
        end
        if (!portEnable) begin
            s_d.rxSt = asd_pkg::RX_HUNT;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
            s_q.rxSync <= 2'h3;
            s_q.txEmpty <= asd_pkg::TX_EMPTY_RST;
            s_q.outLvl <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign serialOut = s_q.outLvl;
    assign serialOutOe = s_q.outOe;
    assign txEmptyFlag = s_q.txEmpty;
    assign txDoneFlag = s_q.txSt == asd_pkg::TX_IDLE && !fifoValid && !s_q.idleQ && !s_q.brkTail && !sendBreak;
    assign txIrq = (s_q.txEmpty && txEmptyIrqEn) || (txDoneFlag && txDoneIrqEn);
    assign rxIrq = s_q.full && rxFullIrqEn;
    assign rxData = s_q.data;
    assign rxNinthBit = s_q.ninth;
    assign rxFullFlag = s_q.full;
    assign framingErrFlag = s_q.fe;
    assign noiseFlag = s_q.nf;
    assign breakFlag = s_q.bk;
    assign overrunFlag = s_q.ovr;
    assign rxActiveFlag = s_q.rxSt != asd_pkg::RX_HUNT;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    property p_release;
        !portEnable |=> !serialOutOe;
    endproperty
    a_release: assert property (p_release) else $error("pin not released");
    property p_idle_level;
        s_q.txSt == asd_pkg::TX_IDLE |-> serialOut == !$past(txInvert);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
    property p_handoff;
        fifoPop |=> txEmptyFlag && s_q.txSt == asd_pkg::TX_DATA && !s_q.txSh[0];
    endproperty
    a_handoff: assert property (p_handoff) else $error("handoff wrong");
    property p_done;
        txDoneFlag |-> s_q.txSt == asd_pkg::TX_IDLE && !fifoValid;
    endproperty
    a_done: assert property (p_done) else $error("done while busy");
    property p_full;
        rxDone |=> rxFullFlag && !rxActiveFlag;
    endproperty
    a_full: assert property (p_full) else $error("full not set");
    property p_frame;
        rxDone && !bitMaj |=> framingErrFlag && rxFullFlag;
    endproperty
    a_frame: assert property (p_frame) else $error("framing flag late");
    property p_break;
        rxDone && !bitMaj && s_q.rxSh == 9'h0 |=> breakFlag && rxData == 8'h0 && !rxNinthBit;
    endproperty
    a_break: assert property (p_break) else $error("break effects missing");
    property p_reject;
        s_q.rtTick && s_q.rxSt == asd_pkg::RX_START && s_q.rxPh == asd_pkg::PH_RT7 && bitMaj
            |=> s_q.rxSt == asd_pkg::RX_HUNT && s_q.ones == 2'h0;
    endproperty
    a_reject: assert property (p_reject) else $error("bad start accepted");
    property p_tick;
        s_q.rtTick |=> !s_q.rtTick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too fast");
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench of the serial port with a remote device model
// Assumes: Shortened sample divider, 20 ns clock
// Notes: Expected results are queued by the driver and popped by monitors
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Short divider keeps frames brief
    localparam int RT_DIV = 2;
    localparam int BIT_NS = 16 * RT_DIV * 20;
    logic clk, reset_n, portEnable, txEnable, sendBreak, txInvert, charNineBitSel, irqEn;
    logic statusRead, txValid, txNinthBit, rxRead, txReady, rxNinthBit, txEmptyFlag, txDoneFlag;
    logic rxFullFlag, framingErrFlag, noiseFlag, breakFlag, overrunFlag, rxActiveFlag;
    logic txIrq, rxIrq, serialIn, serialOut, serialOutOe;
    logic [7:0] txData, rxData;
    // Counters of mismatches and comparisons
    int errors, checks;
    // Expected notes for each direction
    logic [15:0] txExp[$];
    logic [15:0] rxExp[$];

    asd_serial #(.RT_DIV(RT_DIV)) asd_serial_inst (.clk, .reset_n, .portEnable, .txEnable, .sendBreak,
        .txInvert, .charNineBitSel, .txEmptyIrqEn(irqEn), .txDoneIrqEn(irqEn), .rxFullIrqEn(irqEn),
        .statusRead, .txValid, .txReady, .txData, .txNinthBit, .rxRead, .rxData, .rxNinthBit,
        .txEmptyFlag, .txDoneFlag, .rxFullFlag, .framingErrFlag, .noiseFlag, .breakFlag,
        .overrunFlag, .rxActiveFlag, .txIrq, .rxIrq, .serialIn, .serialOut, .serialOutOe);
    asd_remote #(.BIT_NS(BIT_NS)) asd_remote_inst (.serialIn, .serialOut, .serialOutOe,
        .inv(txInvert), .nine(charNineBitSel));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Status read then buffer write, held until taken
    task automatic put(input logic [8:0] w);
        statusRead <= 1'b1;
        @(posedge clk);
        statusRead <= 1'b0;
        txValid <= 1'b1;
        {txNinthBit, txData} <= w;
        do @(posedge clk); while (txReady !== 1'b1);
        txValid <= 1'b0;
    endtask
    // Wait until every queued frame is out and the line is idle
    task automatic drain();
        int n;
        n = 0;
        while ((txExp.size() != 0 || txDoneFlag !== 1'b1) && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk("tx idle", {10'h0, txExp.size() == 0, txDoneFlag, txEmptyFlag, txIrq, serialOutOe,
            serialOut ^ txInvert}, 16'h3F);
    endtask
    // Remote sends a frame, then the buffer is read
    task automatic rx(input logic [8:0] d, input logic stopBit, input logic [15:0] exp);
        rxExp.push_back(exp);
        asd_remote_inst.send(d, stopBit);
        @(posedge clk);
        rxRead <= 1'b1;
        @(posedge clk);
        rxRead <= 1'b0;
    endtask
    // Transmit monitor
    always @(asd_remote_inst.gotEv) begin
        if (txExp.size() == 0) begin
            chk("tx spare frame", 16'h0, 16'h1);
        end else begin
            chk("tx frame", {6'h0, asd_remote_inst.got}, txExp.pop_front());
        end
    end
    // Receive monitor, samples once the flags have landed
    always @(posedge rxFullFlag) begin
        @(negedge clk);
        chk("rx char", {overrunFlag, rxActiveFlag, 1'b0, noiseFlag, rxIrq, breakFlag, framingErrFlag,
            rxNinthBit, rxData}, rxExp.pop_front());
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("timeout");
        print_verdict();
    end
    // Main sequence
    initial begin
        logic [8:0] w;
        void'($urandom(32'h6757));
        {reset_n, portEnable, txEnable, sendBreak, txInvert, charNineBitSel} = '0;
        {statusRead, txValid, txNinthBit, rxRead, txData} = '0;
        irqEn = 1'b1;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Look between edges, where the outputs are settled
        @(negedge clk);
        chk("reset state", {4'h0, rxData, txEmptyFlag, txReady, serialOutOe, rxFullFlag}, 16'h00C);
        $display("test reset done");
        @(posedge clk);
        // Fill the buffer with the transmitter off, then try one refused write
        portEnable <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            w = 9'($urandom());
            put(w);
            txExp.push_back({7'h2, w[7:0]});
        end
        @(posedge clk);
        chk("buffer full", {15'h0, txReady}, 16'h0);
        txValid <= 1'b1;
        repeat (3) @(posedge clk);
        txValid <= 1'b0;
        txEnable <= 1'b1;
        drain();
        $display("test fill and drain done");
        // Nine bit characters with inverted output
        txInvert <= 1'b1;
        charNineBitSel <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            txEnable <= 1'b0;
            @(posedge clk);
            txEnable <= 1'b1;
            w = 9'($urandom());
            put(w);
            txExp.push_back({7'h1, w} | 16'h200);
        end
        drain();
        txInvert <= 1'b0;
        @(posedge clk);
        $display("test nine bit inverted done");
        // Received characters, both lengths, framing error and break
        rx(w, 1'b1, {7'h04, w});
        charNineBitSel <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            w = 9'($urandom());
            rx(w, 1'b1, {7'h04, w[7], w[7:0]});
        end
        // Unread character, then a second one: data kept, overrun set
        rxExp.push_back({7'h04, 9'h03C});
        asd_remote_inst.send(9'h03C, 1'b1);
        asd_remote_inst.send(9'h0C3, 1'b1);
        @(negedge clk);
        chk("rx overrun", {6'h0, overrunFlag, rxFullFlag, rxData}, 16'h33C);
        @(posedge clk);
        rxRead <= 1'b1;
        @(posedge clk);
        rxRead <= 1'b0;
        rx(9'h0A5, 1'b0, {7'h05, 9'h1A5});
        rx(9'h000, 1'b0, {7'h07, 9'h000});
        $display("test receive done");
        print_verdict();
    end
endmodule
